//--- design/burst_fault_seq.sv
// Purpose: burst mode gating and protection sequencing for a flyback switch
// Assumes: comparator results arrive asynchronous; AXI4-Lite register access
// Notes: normal mode switches on valley count or max off time
// Behaviour
// - in paused burst, restart bias and switching when feedback exceeds burst high.
// - burst turn-on comes from a fixed 52 kHz timer, not zero crossing.
// - in burst, gate ends when current exceeds reduced burst peak limit.
// - in burst, gate forced off at half the burst timer period.
// - first of burst current limit or duty limit clears the gate.
// - at burst low feedback, reset bias and hold switching until burst high.
// - feedback above burst exit ends burst and restores normal limit.
// - leaving burst loads the valley counter with one.
// - supply, overload, temperature faults auto-restart; overvoltage, short winding latch.
// - supply under or overvoltage resets control and holds switch off.
// - below turn-off enable charger; above turn-on restart with soft start.
// - persistent high feedback auto-restarts only after 24 ms blanking.
// - zero-cross overvoltage during off time beyond blanking latches off.
// - over-temperature indication forces auto-restart.
// - short winding current while switch on latches off.
// - latched off, charger on at turn-off level, off at turn-on level.
// - gate high longer than max on time turns off at once.
// - burst entry needs low feedback, counter seven, both held for blanking.
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module burst_fault_seq #(
  parameter int OVERLOAD_BLANK_CYC = fly_seq_pkg::OVERLOAD_CYC
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset
  input wire fly_seq_pkg::comp_in_t compIn, // raw comparator levels
  output logic gate, // power switch gate
  output logic biasOn, // internal bias enable
  output logic chargerOn, // startup charger enable
  output logic burstMode, // burst mode active
  output logic burstLimitSel, // reduced current limit selected
  output logic softStart, // pulse: start soft start
  output logic irq, // level interrupt
  input wire logic awvalid, // axi write address valid
  output logic awready, // axi write address ready
  input wire logic [fly_seq_pkg::ADDR_W-1:0] awaddr, // axi write address
  input wire logic wvalid, // axi write data valid
  output logic wready, // axi write data ready
  input wire logic [31:0] wdata, // axi write data
  input wire logic [3:0] wstrb, // axi write strobes
  output logic bvalid, // axi write response valid
  input wire logic bready, // axi write response ready
  output logic [1:0] bresp, // axi write response
  input wire logic arvalid, // axi read address valid
  output logic arready, // axi read address ready
  input wire logic [fly_seq_pkg::ADDR_W-1:0] araddr, // axi read address
  output logic rvalid, // axi read data valid
  input wire logic rready, // axi read ready
  output logic [31:0] rdata, // axi read data
  output logic [1:0] rresp // axi read response
);
  logic [fly_seq_pkg::COMP_W-1:0] syncA_q, syncB_q;
  fly_seq_pkg::comp_in_t cmp;
  fly_seq_pkg::fault_state_t state_q;
  logic gate_q, burst_q, bias_q, charger_q, softStart_q, xingPrev_q;
  logic [2:0] valley_q, xingCnt_q;
  logic [fly_seq_pkg::CNT_W-1:0] onCnt_q, offCnt_q, burstTmr_q, entryCnt_q, ovpCnt_q;
  logic [fly_seq_pkg::BLANK_W-1:0] ovlCnt_q;
  logic ctrlEn_q;
  fly_seq_pkg::evt_t evt_q, mask_q, evtSet;
  logic run, supplyFault, autoFault, latchFault, entryOk, burstExit;
  logic gateOnReq, gateOffReq, burstTick, curTrip, dutyTrip, maxOnTrip;
  logic awHeld_q, wHeld_q, bvalid_q, rvalid_q;
  logic [fly_seq_pkg::ADDR_W-1:0] awAddr_q;
  logic [31:0] wData_q, rdata_q;
  logic [3:0] wStrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic doWrite;

  // two-flop synchronisers, one per comparator bit
  genvar gi;
  generate
    for (gi = 0; gi < fly_seq_pkg::COMP_W; gi++)
    begin : g_sync
      always_ff @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          syncA_q[gi] <= 1'b0;
          syncB_q[gi] <= 1'b0;
        end
        else
        begin
          syncA_q[gi] <= compIn[gi];
          syncB_q[gi] <= syncA_q[gi];
        end
      end
    end
  endgenerate
  assign cmp = fly_seq_pkg::comp_in_t'(syncB_q);

  assign run = (state_q == fly_seq_pkg::ST_RUN);
  assign supplyFault = cmp.vccBelowTurnOff || cmp.vccOvervoltage;
  assign autoFault = supplyFault || cmp.overTemp
    || (ovlCnt_q >= fly_seq_pkg::BLANK_W'(OVERLOAD_BLANK_CYC));
  assign latchFault = (cmp.csShortWinding && gate_q)
    || (ovpCnt_q >= fly_seq_pkg::OVP_BLANK_CYC);

  // protection state machine
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_q <= fly_seq_pkg::ST_RESTART;
    else
    begin
      unique case (state_q)
        fly_seq_pkg::ST_RESTART:
          if (charger_q && cmp.vccAboveTurnOn && !cmp.vccOvervoltage)
            state_q <= fly_seq_pkg::ST_RUN;
        fly_seq_pkg::ST_RUN:
          if (latchFault)
            state_q <= fly_seq_pkg::ST_LATCHED;
          else if (autoFault)
            state_q <= fly_seq_pkg::ST_RESTART;
        fly_seq_pkg::ST_LATCHED:
          state_q <= fly_seq_pkg::ST_LATCHED;
      endcase
    end
  end

  // startup charger hysteresis outside normal run
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      charger_q <= 1'b1;
    else if (run)
      charger_q <= 1'b0;
    else if (cmp.vccBelowTurnOff)
      charger_q <= 1'b1;
    else if (cmp.vccAboveTurnOn)
      charger_q <= 1'b0;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      softStart_q <= 1'b0;
    else
      softStart_q <= (state_q == fly_seq_pkg::ST_RESTART) && charger_q
        && cmp.vccAboveTurnOn && !cmp.vccOvervoltage;
  end

  // fault blanking timers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ovlCnt_q <= '0;
      ovpCnt_q <= '0;
    end
    else
    begin
      if (!run || !cmp.fdbkPulledHigh)
        ovlCnt_q <= '0;
      else
        ovlCnt_q <= ovlCnt_q + 1'b1;
      if (!run || gate_q || !cmp.auxOvervoltage)
        ovpCnt_q <= '0;
      else
        ovpCnt_q <= ovpCnt_q + 1'b1;
    end
  end

  // burst entry and exit
  assign entryOk = cmp.fdbkBelowBurstEntry && (valley_q == fly_seq_pkg::VALLEY_MAX);
  assign burstExit = burst_q && cmp.fdbkAboveBurstExit;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      entryCnt_q <= '0;
    else if (!run || burst_q || !entryOk)
      entryCnt_q <= '0;
    else if (entryCnt_q < fly_seq_pkg::BURST_ENTRY_CYC)
      entryCnt_q <= entryCnt_q + 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      burst_q <= 1'b0;
    else if (!run || burstExit)
      burst_q <= 1'b0;
    else if (entryOk && entryCnt_q >= fly_seq_pkg::BURST_ENTRY_CYC)
      burst_q <= 1'b1;
  end

  // bias gating during burst: paused on entry
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      bias_q <= 1'b0;
    else if (!run)
      bias_q <= 1'b0;
    else if (!burst_q)
      bias_q <= !(entryOk && entryCnt_q >= fly_seq_pkg::BURST_ENTRY_CYC);
    else if (cmp.fdbkAboveBurstHigh)
      bias_q <= 1'b1;
    else if (cmp.fdbkBelowBurstLow)
      bias_q <= 1'b0;
  end

  // valley counter: exit load has priority over software
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      valley_q <= fly_seq_pkg::VALLEY_RST;
    else if (burstExit)
      valley_q <= fly_seq_pkg::VALLEY_EXIT;
    else if (doWrite && awAddr_q == fly_seq_pkg::CTRL_ADDR && wStrb_q[0])
      valley_q <= wData_q[fly_seq_pkg::CTRL_VAL_LSB +: 3];
  end

  // free-running burst timer
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      burstTmr_q <= '0;
    else if (!burst_q || burstTmr_q == fly_seq_pkg::BURST_PERIOD_CYC - 1'b1)
      burstTmr_q <= '0;
    else
      burstTmr_q <= burstTmr_q + 1'b1;
  end
  assign burstTick = burst_q && (burstTmr_q == '0);

  // zero-crossing count while gate off
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xingPrev_q <= 1'b0;
      xingCnt_q <= '0;
    end
    else
    begin
      xingPrev_q <= cmp.zeroCross;
      if (gate_q)
        xingCnt_q <= '0;
      else if (cmp.zeroCross && !xingPrev_q && xingCnt_q != fly_seq_pkg::VALLEY_MAX)
        xingCnt_q <= xingCnt_q + 1'b1;
    end
  end

  assign curTrip = (onCnt_q >= fly_seq_pkg::LEB_CYC)
    && (burst_q ? cmp.csAboveBurstLimit : cmp.csAboveNormalLimit);
  assign dutyTrip = burst_q && (burstTmr_q >= fly_seq_pkg::BURST_HALF_CYC);
  assign maxOnTrip = onCnt_q >= fly_seq_pkg::MAX_ON_CYC;
  assign gateOffReq = curTrip || dutyTrip || maxOnTrip;
  assign gateOnReq = burst_q ? (burstTick && bias_q)
    : (xingCnt_q >= valley_q || offCnt_q >= fly_seq_pkg::MAX_OFF_CYC);

  // gate flip-flop and on/off timers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gate_q <= 1'b0;
      onCnt_q <= '0;
      offCnt_q <= '0;
    end
    else
    begin
      if (!run || !ctrlEn_q || latchFault || autoFault)
        gate_q <= 1'b0;
      else if (gate_q && gateOffReq)
        gate_q <= 1'b0;
      else if (!gate_q && gateOnReq && !burstExit && (bias_q || burst_q))
        gate_q <= 1'b1;
      onCnt_q <= gate_q ? onCnt_q + 1'b1 : '0;
      offCnt_q <= (gate_q || offCnt_q >= fly_seq_pkg::MAX_OFF_CYC) ? offCnt_q : offCnt_q + 1'b1;
      if (gate_q)
        offCnt_q <= '0;
    end
  end

  // interrupt events, set wins over clear
  assign evtSet = '{maxOnTrip: gate_q && maxOnTrip,
                    latchOff: run && latchFault,
                    autoRestart: run && !latchFault && autoFault,
                    burstExit: burstExit,
                    burstEnter: run && !burst_q && entryOk
                      && entryCnt_q >= fly_seq_pkg::BURST_ENTRY_CYC};
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      evt_q <= '0;
    else if (doWrite && awAddr_q == fly_seq_pkg::EVT_ADDR && wStrb_q[0])
      evt_q <= (evt_q & ~fly_seq_pkg::evt_t'(wData_q[fly_seq_pkg::EVT_W-1:0])) | evtSet;
    else
      evt_q <= evt_q | evtSet;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mask_q <= '0;
      ctrlEn_q <= 1'b1;
    end
    else if (doWrite && wStrb_q[0])
    begin
      if (awAddr_q == fly_seq_pkg::MASK_ADDR)
        mask_q <= fly_seq_pkg::evt_t'(wData_q[fly_seq_pkg::EVT_W-1:0]);
      if (awAddr_q == fly_seq_pkg::CTRL_ADDR)
        ctrlEn_q <= wData_q[fly_seq_pkg::CTRL_EN_BIT];
    end
  end

  // axi4-lite write channel
  assign doWrite = awHeld_q && wHeld_q && !bvalid_q;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= fly_seq_pkg::RESP_OKAY;
      awAddr_q <= '0;
      wData_q <= '0;
      wStrb_q <= '0;
    end
    else
    begin
      if (awvalid && !awHeld_q)
      begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && !wHeld_q)
      begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite)
      begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q <= (awAddr_q == fly_seq_pkg::STAT_ADDR || awAddr_q[1:0] != 2'h0)
          ? fly_seq_pkg::RESP_SLVERR : fly_seq_pkg::RESP_OKAY;
      end
      else if (bvalid_q && bready)
        bvalid_q <= 1'b0;
    end
  end

  // axi4-lite read channel
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= fly_seq_pkg::RESP_OKAY;
    end
    else if (arvalid && !rvalid_q)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= fly_seq_pkg::RESP_OKAY;
      rdata_q <= '0;
      unique case (araddr)
        fly_seq_pkg::CTRL_ADDR: rdata_q <= {28'h0, valley_q, ctrlEn_q};
        fly_seq_pkg::STAT_ADDR:
          rdata_q <= {23'h0, state_q, xingCnt_q, charger_q, bias_q, burst_q, gate_q};
        fly_seq_pkg::EVT_ADDR: rdata_q <= {27'h0, evt_q};
        fly_seq_pkg::MASK_ADDR: rdata_q <= {27'h0, mask_q};
        default: rresp_q <= fly_seq_pkg::RESP_SLVERR;
      endcase
    end
    else if (rvalid_q && rready)
      rvalid_q <= 1'b0;
  end

  assign awready = !awHeld_q;
  assign wready = !wHeld_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;
  assign gate = gate_q;
  assign biasOn = bias_q;
  assign chargerOn = charger_q;
  assign burstMode = burst_q;
  assign burstLimitSel = burst_q;
  assign softStart = softStart_q;
  assign irq = |(evt_q & mask_q);

  a_burst_duty: assert property (@(posedge clk) disable iff (!rst_n)
    burst_q && gate_q && burstTmr_q >= fly_seq_pkg::BURST_HALF_CYC |=> !gate_q)
    else $error("burst duty limit missed");
  a_burst_cur: assert property (@(posedge clk) disable iff (!rst_n)
    gate_q && burst_q && curTrip |=> !gate_q)
    else $error("burst current limit missed");
  a_burst_timer: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(gate_q) && $past(burst_q) |-> $past(burstTmr_q) == '0)
    else $error("burst turn-on off timer");
  a_max_on: assert property (@(posedge clk) disable iff (!rst_n)
    gate_q |-> onCnt_q <= fly_seq_pkg::MAX_ON_CYC)
    else $error("gate exceeded max on time");
  a_exit_valley: assert property (@(posedge clk) disable iff (!rst_n)
    burstExit |=> !burst_q && valley_q == fly_seq_pkg::VALLEY_EXIT)
    else $error("burst exit did not load valley");
  a_bias_low: assert property (@(posedge clk) disable iff (!rst_n)
    burst_q && cmp.fdbkBelowBurstLow && !cmp.fdbkAboveBurstHigh && run |=> !bias_q)
    else $error("bias not reset at burst low");
  a_bias_high: assert property (@(posedge clk) disable iff (!rst_n)
    burst_q && run && cmp.fdbkAboveBurstHigh && !burstExit |=> bias_q)
    else $error("bias not restored at burst high");
  a_latch_short: assert property (@(posedge clk) disable iff (!rst_n)
    run && gate_q && cmp.csShortWinding |=> state_q == fly_seq_pkg::ST_LATCHED)
    else $error("short winding did not latch");
  a_latch_hold: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == fly_seq_pkg::ST_LATCHED |=> state_q == fly_seq_pkg::ST_LATCHED && !gate_q)
    else $error("latched state left");
  a_supply_off: assert property (@(posedge clk) disable iff (!rst_n)
    run && cmp.vccOvervoltage |=> !gate_q && !run)
    else $error("supply fault kept switching");
  a_temp_restart: assert property (@(posedge clk) disable iff (!rst_n)
    run && cmp.overTemp && !latchFault |=> state_q == fly_seq_pkg::ST_RESTART)
    else $error("over temperature ignored");
  c_burst_enter: cover property (@(posedge clk) disable iff (!rst_n) $rose(burst_q));
  c_burst_exit: cover property (@(posedge clk) disable iff (!rst_n) burstExit);
  c_latched: cover property (@(posedge clk) disable iff (!rst_n)
    state_q == fly_seq_pkg::ST_LATCHED && $rose(charger_q));
endmodule
`default_nettype wire

//--- design/fly_seq_pkg.sv
// Purpose: shared constants and types for the burst and fault sequencer
// Assumes: 25 MHz core clock
// Notes: times kept in their own units, cycle counts derived below
package fly_seq_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int CLK_MHZ = 25;
  localparam int BURST_FREQ_HZ = 52_000;
  localparam int BURST_DUTY_PCT = 50;
  localparam int MAX_ON_NS = 30_000;
  localparam int LEB_NS = 200;
  localparam int MAX_OFF_US = 50;
  localparam int BURST_ENTRY_US = 100;
  localparam int OVERLOAD_MS = 24;
  localparam int OVP_BLANK_NS = 1_000;
  localparam int CNT_W = 12;
  localparam int BLANK_W = 20;
  localparam logic [CNT_W-1:0] BURST_PERIOD_CYC = CNT_W'(CLK_HZ / BURST_FREQ_HZ);
  localparam logic [CNT_W-1:0] BURST_HALF_CYC =
    CNT_W'(CLK_HZ / BURST_FREQ_HZ * BURST_DUTY_PCT / 100);
  localparam logic [CNT_W-1:0] MAX_ON_CYC = CNT_W'(MAX_ON_NS * CLK_MHZ / 1000);
  localparam logic [CNT_W-1:0] LEB_CYC = CNT_W'((LEB_NS * CLK_MHZ + 999) / 1000);
  localparam logic [CNT_W-1:0] MAX_OFF_CYC = CNT_W'(MAX_OFF_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] BURST_ENTRY_CYC = CNT_W'(BURST_ENTRY_US * CLK_MHZ);
  localparam logic [CNT_W-1:0] OVP_BLANK_CYC = CNT_W'((OVP_BLANK_NS * CLK_MHZ) / 1000);
  localparam int OVERLOAD_CYC = OVERLOAD_MS * CLK_MHZ * 1000;
  localparam logic [2:0] VALLEY_MAX = 3'h7;
  localparam logic [2:0] VALLEY_EXIT = 3'h1;
  localparam logic [2:0] VALLEY_RST = 3'h1;
  // register map, byte addresses
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] CTRL_ADDR = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 4'h4;
  localparam logic [ADDR_W-1:0] EVT_ADDR = 4'h8;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 4'hc;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_VAL_LSB = 1;
  localparam int EVT_W = 5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {ST_RESTART, ST_RUN, ST_LATCHED} fault_state_t;
  typedef struct packed {
    logic fdbkAboveBurstHigh;
    logic fdbkBelowBurstLow;
    logic fdbkAboveBurstExit;
    logic fdbkBelowBurstEntry;
    logic fdbkPulledHigh;
    logic csAboveBurstLimit;
    logic csAboveNormalLimit;
    logic csShortWinding;
    logic zeroCross;
    logic auxOvervoltage;
    logic vccBelowTurnOff;
    logic vccAboveTurnOn;
    logic vccOvervoltage;
    logic overTemp;
  } comp_in_t;
  localparam int COMP_W = $bits(comp_in_t);
  // sticky event bits
  typedef struct packed {
    logic maxOnTrip;
    logic latchOff;
    logic autoRestart;
    logic burstExit;
    logic burstEnter;
  } evt_t;
endpackage

//--- verif/switch_stage_model.sv
// Purpose: far side of the sequencer: switch stage, feedback loop, aux winding
// Assumes: bench sets the static comparator levels in env
// Notes: sense current and ringing react to the gate; faults gated by switch phase
`timescale 1ns/1ps
`default_nettype none
module switch_stage_model (
  input wire logic clk, // core clock
  input wire logic gate, // gate from device
  input wire fly_seq_pkg::comp_in_t env, // static levels from bench
  input wire logic [11:0] csDelay, // on cycles to burst limit, 0 never
  output fly_seq_pkg::comp_in_t compIn // comparator levels to device
);
  logic [11:0] onCnt = 12'h0;
  logic [11:0] offCnt = 12'h0;
  always_ff @(posedge clk)
  begin
    onCnt <= gate ? onCnt + 12'h1 : 12'h0;
    offCnt <= gate ? 12'h0 : offCnt + 12'h1;
  end
  // current ramps while on; normal limit sits at twice the burst limit
  always_comb
  begin
    compIn = env;
    compIn.csAboveBurstLimit = csDelay != 12'h0 && onCnt >= csDelay;
    compIn.csAboveNormalLimit = csDelay != 12'h0 && onCnt >= {csDelay[10:0], 1'b0};
    compIn.csShortWinding = env.csShortWinding && gate;
    compIn.zeroCross = offCnt[3] && offCnt < 12'h40;
    compIn.auxOvervoltage = env.auxOvervoltage && !gate;
  end
endmodule
`default_nettype wire

//--- verif/test_burst_fault_seq.sv
// Purpose: self-checking bench for the burst and fault sequencer
// Assumes: short overload blanking via parameter
// Notes: one task per scenario
`timescale 1ns/1ps
`default_nettype none
module test_burst_fault_seq;
  localparam int BLANK = 50;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  fly_seq_pkg::comp_in_t env = '0;
  fly_seq_pkg::comp_in_t compIn;
  logic [11:0] csDelay = 12'h0;
  logic gate, biasOn, chargerOn, burstMode, burstLimitSel, softStart, irq;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0, wstrb = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata, rd;
  logic [1:0] bresp, rresp, rs;
  int errors = 0, nChecks = 0, cyc = 0;
  always #20 clk = ~clk;
  burst_fault_seq #(.OVERLOAD_BLANK_CYC(BLANK)) burst_fault_seq_inst (.clk(clk), .rst_n(rst_n),
    .compIn(compIn), .gate(gate), .biasOn(biasOn), .chargerOn(chargerOn), .burstMode(burstMode),
    .burstLimitSel(burstLimitSel), .softStart(softStart), .irq(irq), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));
  switch_stage_model switch_stage_model_inst (.clk(clk), .gate(gate), .env(env),
    .csDelay(csDelay), .compIn(compIn));
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", nChecks, errors);
    if (errors == 0 && nChecks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      errors++;
      $display("Error run length expected end seen hang");
      tally_and_finish();
    end
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    nChecks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic okIf(input string what, input logic c);
    check(what, 32'h1, {31'h0, c});
  endtask
  task automatic waitVal(ref logic s, input logic v, input int lim, output int n);
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (s !== v && n < lim);
  endtask
  task automatic axiWr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  task automatic axiRd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic done;
    done = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge clk);
      if (arready)
        arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask
  // cycles of the next full gate pulse
  task automatic hiLen(output int n);
    int w;
    waitVal(gate, 1'b0, 2000, w);
    waitVal(gate, 1'b1, 3000, w);
    n = 0;
    while (gate === 1'b1 && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic stateIs(input logic [1:0] st);
    axiRd(fly_seq_pkg::STAT_ADDR, rd, rs);
    check("state", {30'h0, st}, {30'h0, rd[8:7]});
  endtask
  task automatic rerun();
    int w;
    env.vccAboveTurnOn <= 1'b0;
    env.vccBelowTurnOff <= 1'b1;
    waitVal(chargerOn, 1'b1, 10, w);
    okIf("charger on", w < 10);
    okIf("gate held off", gate === 1'b0);
    env.vccBelowTurnOff <= 1'b0;
    env.vccAboveTurnOn <= 1'b1;
    waitVal(softStart, 1'b1, 20, w);
    okIf("soft start", w < 20);
    stateIs(2'h1);
  endtask
  task automatic tStart();
    axiRd(fly_seq_pkg::STAT_ADDR, rd, rs);
    check("status reset", 32'h8, rd & 32'h18f);
    axiRd(fly_seq_pkg::CTRL_ADDR, rd, rs);
    check("ctrl reset", 32'h3, rd);
    axiRd(fly_seq_pkg::EVT_ADDR, rd, rs);
    check("events reset", 32'h0, rd);
    axiWr(fly_seq_pkg::STAT_ADDR, 32'h1, rs);
    check("status write", {30'h0, fly_seq_pkg::RESP_SLVERR}, {30'h0, rs});
    axiRd(4'h6, rd, rs);
    check("unmapped read", {30'h0, fly_seq_pkg::RESP_SLVERR}, {30'h0, rs});
    rerun();
    $display("start done");
  endtask
  task automatic tMaxOn();
    int h, w;
    axiWr(fly_seq_pkg::MASK_ADDR, 32'h0, rs);
    hiLen(h);
    okIf("max on time", h >= 748 && h <= 752);
    okIf("irq masked", irq === 1'b0);
    axiRd(fly_seq_pkg::EVT_ADDR, rd, rs);
    okIf("max on event", rd[4] === 1'b1);
    axiWr(fly_seq_pkg::MASK_ADDR, 32'h10, rs);
    okIf("irq raised", irq === 1'b1);
    csDelay <= 12'd100;
    hiLen(h);
    okIf("normal limit", h >= 199 && h <= 208);
    axiWr(fly_seq_pkg::EVT_ADDR, 32'h10, rs);
    waitVal(irq, 1'b0, 5, w);
    okIf("irq cleared", w < 5);
    $display("max on done");
  endtask
  task automatic tBurst();
    int h, w;
    axiWr(fly_seq_pkg::CTRL_ADDR, 32'hf, rs);
    env.fdbkBelowBurstEntry <= 1'b1;
    waitVal(burstMode, 1'b1, 3000, w);
    okIf("entry blanking", w >= 2498 && w <= 2510);
    okIf("burst limit", burstLimitSel === 1'b1);
    waitVal(gate, 1'b0, 800, w);
    waitVal(gate, 1'b1, 600, w);
    okIf("paused", gate === 1'b0 && biasOn === 1'b0);
    env.fdbkBelowBurstEntry <= 1'b0;
    env.fdbkAboveBurstHigh <= 1'b1;
    csDelay <= 12'h0;
    waitVal(biasOn, 1'b1, 6, w);
    okIf("bias resume", w < 6);
    hiLen(h);
    waitVal(gate, 1'b1, 600, w);
    okIf("duty limit", h >= 239 && h <= 241);
    check("burst period", 32'd480, h + w);
    csDelay <= 12'd40;
    hiLen(h);
    okIf("burst current", h >= 40 && h <= 46);
    env.fdbkAboveBurstHigh <= 1'b0;
    env.fdbkBelowBurstLow <= 1'b1;
    waitVal(biasOn, 1'b0, 6, w);
    okIf("bias reset", w < 6);
    waitVal(gate, 1'b0, 300, w);
    waitVal(gate, 1'b1, 600, w);
    okIf("held off", gate === 1'b0);
    env.fdbkBelowBurstLow <= 1'b0;
    env.fdbkAboveBurstExit <= 1'b1;
    waitVal(burstMode, 1'b0, 6, w);
    okIf("burst exit", w < 6 && burstLimitSel === 1'b0);
    axiRd(fly_seq_pkg::CTRL_ADDR, rd, rs);
    check("valley load", 32'h1, {29'h0, rd[3:1]});
    axiRd(fly_seq_pkg::EVT_ADDR, rd, rs);
    check("burst events", 32'h3, {30'h0, rd[1:0]});
    hiLen(h);
    okIf("full limit", h >= 78);
    env.fdbkAboveBurstExit <= 1'b0;
    $display("burst done");
  endtask
  task automatic tAuto();
    for (int k = 0; k < 3; k++)
    begin
      axiWr(fly_seq_pkg::EVT_ADDR, 32'h1f, rs);
      env.overTemp <= k == 0;
      env.vccOvervoltage <= k == 1;
      env.fdbkPulledHigh <= k == 2;
      repeat (BLANK - 10) @(posedge clk);
      axiRd(fly_seq_pkg::EVT_ADDR, rd, rs);
      okIf("blanking", rd[2] === (k != 2));
      repeat (40) @(posedge clk);
      axiRd(fly_seq_pkg::EVT_ADDR, rd, rs);
      okIf("auto restart", rd[2] === 1'b1);
      env.overTemp <= 1'b0;
      env.vccOvervoltage <= 1'b0;
      env.fdbkPulledHigh <= 1'b0;
      rerun();
    end
    $display("auto restart done");
  endtask
  task automatic tLatch();
    int w;
    for (int k = 0; k < 2; k++)
    begin
      axiWr(fly_seq_pkg::CTRL_ADDR, 32'hf, rs);
      waitVal(gate, 1'b0, 2000, w);
      if (k == 1)
      begin
        env.auxOvervoltage <= 1'b1;
        repeat (10) @(posedge clk);
        env.auxOvervoltage <= 1'b0;
        stateIs(2'h1);
      end
      env.csShortWinding <= k == 0;
      env.auxOvervoltage <= k == 1;
      repeat (1500) @(posedge clk);
      stateIs(2'h2);
      okIf("latched gate", gate === 1'b0);
      env.csShortWinding <= 1'b0;
      env.auxOvervoltage <= 1'b0;
      env.vccAboveTurnOn <= 1'b0;
      env.vccBelowTurnOff <= 1'b1;
      waitVal(chargerOn, 1'b1, 6, w);
      okIf("latch charger on", w < 6);
      env.vccBelowTurnOff <= 1'b0;
      env.vccAboveTurnOn <= 1'b1;
      waitVal(chargerOn, 1'b0, 6, w);
      okIf("latch charger off", w < 6);
      stateIs(2'h2);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      rerun();
    end
    $display("latch done");
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    tStart();
    tMaxOn();
    tBurst();
    tAuto();
    tLatch();
    tally_and_finish();
  end
endmodule
`default_nettype wire
